// >>> src/cgr_params.svh
/*
  Offsets, field positions, masks and reset values of the upper global
  configuration registers. Definitions only; included by the package and
  the design modules.
*/
`ifndef CGR_PARAMS_SVH
`define CGR_PARAMS_SVH

// register indices seen through the index port
`define CGR_OFF_AUTOPM 8'h23
`define CGR_OFF_OSC 8'h24
`define CGR_OFF_RSVD_A 8'h25
`define CGR_OFF_ADDR_LO 8'h26
`define CGR_OFF_ADDR_HI 8'h27
`define CGR_OFF_RSVD_B 8'h28
`define CGR_OFF_RSVD_C 8'h29
`define CGR_OFF_TEST_F 8'h2a
`define CGR_OFF_TEST_D 8'h2b
`define CGR_OFF_TEST_E 8'h2c
`define CGR_OFF_TEST_A 8'h2d
`define CGR_OFF_TEST_B 8'h2e
`define CGR_OFF_TEST_C 8'h2f
`define CGR_TEST_FIRST 8'h2a
`define CGR_TEST_COUNT 6

// writable bit masks
`define CGR_AUTOPM_MASK 8'h79
`define CGR_OSC_MASK 8'h4e
`define CGR_ADDR_LO_MASK 8'hfe

// field positions
`define CGR_PM_FLOPPY 0
`define CGR_PM_PARALLEL 3
`define CGR_PM_SERIAL1 4
`define CGR_PM_SERIAL2 5
`define CGR_PM_MIDI 6
`define CGR_OSC_PLL_OFF 1
`define CGR_OSC_FLD_LO 2
`define CGR_OSC_FLD_HI 3
`define CGR_OSC_QUAL16 6
`define CGR_KBC_HOLD_BIT 6
`define CGR_OSC_STOP_CODE 2'h3

// reset values
`define CGR_AUTOPM_RST 8'h00
`define CGR_OSC_RST 8'h44
`define CGR_ADDR_LO_STRAP0 8'h2e
`define CGR_ADDR_LO_STRAP1 8'h4e
`define CGR_ADDR_HI_RST 8'h00
`define CGR_TEST_RST 8'h00

// index-port decode masks
`define CGR_QUAL12_MASK 16'h0fff
`define CGR_QUAL16_MASK 16'hffff

`endif

// >>> src/cgr_pkg.sv
/*
  Types shared by the global configuration register modules.
  Assumes cgr_params.svh is on the include path.
*/
`include "cgr_params.svh"

package cgr_pkg;
  // one register byte
  typedef logic [7:0] cgr_byte_t;
  // test register image
  typedef logic [`CGR_TEST_COUNT-1:0][7:0] cgr_test_t;

  // state of the main register block
  typedef struct packed {
    cgr_byte_t idx;
    cgr_byte_t autopm;
    cgr_byte_t osc;
    cgr_byte_t addr_lo;
    cgr_byte_t addr_hi;
    logic [15:0] base;
    logic strap_pend;
    cgr_byte_t rdata;
  } cgr_main_s;

  // state of the test register bank
  typedef struct packed {
    cgr_test_t bytes;
  } cgr_test_s;
endpackage

// >>> src/cgr_test_bank.sv
/*
  Six factory test registers, read/write, cleared only by power-on resets.
  Assumes the caller gates writes with configuration mode and index decode.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cgr_params.svh"

module cgr_test_bank
  import cgr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_clear,
  input wire logic i_wr,
  input wire logic [2:0] i_sel,
  input wire cgr_pkg::cgr_byte_t i_wdata,
  output cgr_pkg::cgr_test_t o_bytes
);
  import cgr_pkg::*;

  cgr_test_s st; // registered state
  cgr_test_s next_st; // next state

  // next state: power-on clear first, then byte write
  always_comb
  begin
    next_st = st;
    if (i_clear)
    begin
      next_st.bytes = '0;
    end
    else if (i_wr && (i_sel < 3'(`CGR_TEST_COUNT)))
    begin
      next_st.bytes[i_sel] = i_wdata;
    end
  end

  // state register, cleared on main power-on reset
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign o_bytes = st.bytes;
endmodule
`default_nettype wire

// >>> src/cgr_global_regs.sv
/*
  Upper global configuration registers (0x23..0x2f) behind the index and
  data ports, plus the relocatable configuration port decode.
  Assumes: i_rstn is the main-supply power-on reset; standby power-on,
  bus and soft resets arrive as synchronous one-cycle pulses; the strap
  pin and all port strobes are synchronous to i_clk.
*/
// Functional notes
// - autopower enables at bits 0,3,4,5,6
// - autopower clears on three resets; reserved zero
// - osc bit 1 stops the PLL
// - osc code 11 stops oscillator and baud
// - osc bit 6 picks 16-bit qualification
// - osc bits 0,4,5,7 reserved
// - offsets 25,28,29 ignore writes, read zero
// - low address byte, strap default, bit0 zero
// - high address byte defaults to zero
// - base moves on high byte write
// - address reset by bus and main POR only
// - test byte bit 6 holds keyboard controller
// - test registers cleared by power-on resets only
// - access only in configuration mode via index/data
`timescale 1ns/1ps
`default_nettype none
`include "cgr_params.svh"

module cgr_global_regs
  import cgr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_standby_por,
  input wire logic i_bus_reset,
  input wire logic i_soft_reset,
  input wire logic i_cfg_strap,
  input wire logic i_cfg_mode,
  input wire logic i_index_wr,
  input wire logic i_data_wr,
  input wire logic i_data_rd,
  input wire cgr_pkg::cgr_byte_t i_wdata,
  input wire logic i_io_valid,
  input wire logic [15:0] i_io_addr,
  output cgr_pkg::cgr_byte_t o_rdata,
  output logic o_floppy_autopm,
  output logic o_parallel_autopm,
  output logic o_serial1_autopm,
  output logic o_serial2_autopm,
  output logic o_midi_autopm,
  output logic o_pll_stop,
  output logic o_osc_stop,
  output logic o_baud_clock_generator_en,
  output logic o_addr16_qual,
  output logic o_kbc_reset,
  output logic [15:0] o_cfg_base,
  output logic o_index_hit,
  output logic o_data_hit
);
  import cgr_pkg::*;

  cgr_main_s st; // registered state
  cgr_main_s next_st; // next state
  cgr_test_t test_bytes; // test register image
  logic wr_ok; // data write accepted
  logic rd_ok; // data read accepted
  logic test_sel; // index points at a test register
  logic [7:0] test_ofs; // index minus first test offset
  logic [15:0] qual_mask; // address bits compared
  logic base_match; // upper address bits equal base
  cgr_byte_t rd_val; // value the index selects
  cgr_byte_t strap_lo; // strap default of low byte

  assign wr_ok = i_cfg_mode && i_data_wr;
  assign rd_ok = i_cfg_mode && i_data_rd;
  assign test_ofs = st.idx - `CGR_TEST_FIRST;
  assign test_sel = (st.idx >= `CGR_TEST_FIRST) && (st.idx <= `CGR_OFF_TEST_C);
  assign strap_lo = i_cfg_strap ? `CGR_ADDR_LO_STRAP1 : `CGR_ADDR_LO_STRAP0;

  // factory test bytes, cleared by either power-on reset
  // POR-only test clear
  cgr_test_bank u_test
  (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_clear(i_standby_por),
    .i_wr(wr_ok && test_sel),
    .i_sel(test_ofs[2:0]),
    .i_wdata(i_wdata),
    .o_bytes(test_bytes)
  );

  // read multiplexer over the full 8-bit index
  always_comb
  begin
    rd_val = 8'h00;
    unique case (st.idx)
      `CGR_OFF_AUTOPM: rd_val = st.autopm;
      `CGR_OFF_OSC: rd_val = st.osc;
      `CGR_OFF_ADDR_LO: rd_val = st.addr_lo;
      `CGR_OFF_ADDR_HI: rd_val = st.addr_hi;
      default:
      begin
        if (test_sel)
        begin
          rd_val = test_bytes[test_ofs[2:0]];
        end
      end
    endcase
  end

  // next state: resets beat writes
  always_comb
  begin
    next_st = st;
    // index register, full 8 bits
    if (i_cfg_mode && i_index_wr)
    begin
      next_st.idx = i_wdata;
    end
    // register writes through the data port
    if (wr_ok)
    begin
      unique case (st.idx)
        `CGR_OFF_AUTOPM: next_st.autopm = i_wdata & `CGR_AUTOPM_MASK;
        `CGR_OFF_OSC: next_st.osc = i_wdata & `CGR_OSC_MASK;
        `CGR_OFF_ADDR_LO: next_st.addr_lo = i_wdata & `CGR_ADDR_LO_MASK;
        `CGR_OFF_ADDR_HI:
        begin
          next_st.addr_hi = i_wdata;
          next_st.base = {i_wdata, st.addr_lo};
        end
        default: next_st.idx = next_st.idx;
      endcase
    end
    // strap default once after main power-on
    if (st.strap_pend)
    begin
      next_st.strap_pend = 1'b0;
      next_st.addr_lo = strap_lo;
      next_st.base = {`CGR_ADDR_HI_RST, strap_lo};
    end
    // soft reset clears only the index selection
    if (i_soft_reset)
    begin
      next_st.idx = 8'h00;
    end
    if (i_standby_por)
    begin
      next_st.idx = 8'h00;
      next_st.autopm = `CGR_AUTOPM_RST;
      next_st.osc = `CGR_OSC_RST;
    end
    if (i_bus_reset)
    begin
      next_st.idx = 8'h00;
      next_st.autopm = `CGR_AUTOPM_RST;
      next_st.osc = `CGR_OSC_RST;
      next_st.addr_lo = strap_lo;
      next_st.addr_hi = `CGR_ADDR_HI_RST;
      next_st.base = {`CGR_ADDR_HI_RST, strap_lo};
      next_st.strap_pend = 1'b0;
    end
    // read data held until the next accepted read
    if (rd_ok)
    begin
      next_st.rdata = rd_val;
    end
  end

  // state register; main power-on reset loads constants only
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st.idx <= 8'h00;
      st.autopm <= `CGR_AUTOPM_RST;
      st.osc <= `CGR_OSC_RST;
      st.addr_lo <= `CGR_ADDR_LO_STRAP0;
      st.addr_hi <= `CGR_ADDR_HI_RST;
      st.base <= {`CGR_ADDR_HI_RST, `CGR_ADDR_LO_STRAP0};
      st.strap_pend <= 1'b1;
      st.rdata <= 8'h00;
    end
    else
    begin
      st <= next_st;
    end
  end

  // function enables straight from the register
  assign o_floppy_autopm = st.autopm[`CGR_PM_FLOPPY];
  assign o_parallel_autopm = st.autopm[`CGR_PM_PARALLEL];
  assign o_serial1_autopm = st.autopm[`CGR_PM_SERIAL1];
  assign o_serial2_autopm = st.autopm[`CGR_PM_SERIAL2];
  assign o_midi_autopm = st.autopm[`CGR_PM_MIDI];
  assign o_pll_stop = st.osc[`CGR_OSC_PLL_OFF];
  assign o_osc_stop = (st.osc[`CGR_OSC_FLD_HI:`CGR_OSC_FLD_LO] == `CGR_OSC_STOP_CODE);
  assign o_baud_clock_generator_en = !o_osc_stop;
  assign o_addr16_qual = st.osc[`CGR_OSC_QUAL16];
  assign o_kbc_reset = test_bytes[`CGR_OFF_TEST_E - `CGR_TEST_FIRST][`CGR_KBC_HOLD_BIT];
  assign o_cfg_base = st.base;
  assign o_rdata = st.rdata;

  assign qual_mask = o_addr16_qual ? `CGR_QUAL16_MASK : `CGR_QUAL12_MASK;
  assign base_match = (((i_io_addr ^ st.base) & qual_mask) >> 1) == 16'h0000;
  assign o_index_hit = i_io_valid && base_match && !i_io_addr[0];
  assign o_data_hit = i_io_valid && base_match && i_io_addr[0];

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  // writes to the high byte after a low byte write
  sequence s_lo_wr;
    wr_ok && st.idx == `CGR_OFF_ADDR_LO && !i_bus_reset;
  endsequence
  sequence s_hi_wr;
    wr_ok && st.idx == `CGR_OFF_ADDR_HI && !i_bus_reset && !st.strap_pend;
  endsequence

  property p_autopm_reserved;
    (st.autopm & ~`CGR_AUTOPM_MASK) == 8'h00;
  endproperty
  a_autopm_reserved: assert property (p_autopm_reserved)
    else $error("reserved autopower bits set");

  property p_autopm_clear;
    (i_standby_por || i_bus_reset) |=> (st.autopm == 8'h00 && st.osc == 8'h44);
  endproperty
  a_autopm_clear: assert property (p_autopm_clear)
    else $error("autopower not cleared by reset");

  property p_autopm_write;
    (wr_ok && st.idx == `CGR_OFF_AUTOPM && !i_standby_por && !i_bus_reset)
      |=> o_midi_autopm == $past(i_wdata[6]) && o_floppy_autopm == $past(i_wdata[0]);
  endproperty
  a_autopm_write: assert property (p_autopm_write)
    else $error("autopower enable not written");

  property p_osc_stop;
    o_osc_stop == (st.osc[3:2] == 2'b11) && o_baud_clock_generator_en == !o_osc_stop;
  endproperty
  a_osc_stop: assert property (p_osc_stop)
    else $error("oscillator stop decode wrong");

  property p_reserved_read;
    (rd_ok && (st.idx == 8'h25 || st.idx == 8'h28 || st.idx == 8'h29)) |=> o_rdata == 8'h00;
  endproperty
  a_reserved_read: assert property (p_reserved_read)
    else $error("reserved location read nonzero");

  property p_lo_even;
    !st.addr_lo[0] && !st.base[0];
  endproperty
  a_lo_even: assert property (p_lo_even)
    else $error("configuration address bit 0 set");

  property p_relocate;
    s_lo_wr ##1 (!i_data_wr)[*3] ##1 s_hi_wr
      |=> o_cfg_base == {$past(i_wdata), $past(st.addr_lo)};
  endproperty
  a_relocate: assert property (p_relocate)
    else $error("base not moved on high byte write");

  property p_lo_no_move;
    (s_lo_wr and !st.strap_pend) |=> o_cfg_base == $past(o_cfg_base);
  endproperty
  a_lo_no_move: assert property (p_lo_no_move)
    else $error("base moved on low byte write");

  property p_addr_keep;
    ((i_standby_por || i_soft_reset) && !i_bus_reset && !wr_ok && !st.strap_pend)
      |=> $stable(o_cfg_base);
  endproperty
  a_addr_keep: assert property (p_addr_keep)
    else $error("address lost on standby or soft reset");

  property p_bus_default;
    i_bus_reset |=> (o_cfg_base[15:8] == 8'h00) && st.addr_hi == 8'h00;
  endproperty
  a_bus_default: assert property (p_bus_default)
    else $error("high address byte not defaulted");

  property p_no_mode_write;
    (!i_cfg_mode && !i_standby_por && !i_bus_reset && !i_soft_reset) |=> $stable(st.autopm);
  endproperty
  a_no_mode_write: assert property (p_no_mode_write)
    else $error("register changed outside configuration mode");

  property p_qual12;
    (i_io_valid && !o_addr16_qual && i_io_addr[11:0] == st.base[11:0]) |-> o_index_hit;
  endproperty
  a_qual12: assert property (p_qual12)
    else $error("12-bit decode missed index port");

  property p_test_keep;
    (i_bus_reset && !i_standby_por && !wr_ok) |=> $stable(o_kbc_reset);
  endproperty
  a_test_keep: assert property (p_test_keep)
    else $error("test register cleared by bus reset");
endmodule
`default_nettype wire

// >>> dv/cgr_host_model.sv
/*
  Host software model: drives the index and data port strobes.
  Assumes the block samples the strobes on the rising edge of i_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module cgr_host_model (
  input wire logic i_clk,
  input wire cgr_pkg::cgr_byte_t i_rdata,
  output logic o_cfg_mode,
  output logic o_index_wr,
  output logic o_data_wr,
  output logic o_data_rd,
  output cgr_pkg::cgr_byte_t o_wdata
);
  import cgr_pkg::*;

  // idle port at time zero
  initial
  begin
    o_cfg_mode = 1'b0;
    {o_index_wr, o_data_wr, o_data_rd} = 3'b000;
    o_wdata = 8'h00;
  end

  // one strobe cycle, launched and dropped on falling edges
  task automatic strobe(input logic [2:0] s, input cgr_byte_t d);
    @(negedge i_clk);
    {o_index_wr, o_data_wr, o_data_rd} = s;
    o_wdata = d;
    @(negedge i_clk);
    {o_index_wr, o_data_wr, o_data_rd} = 3'b000;
    // released data shows the inverse, never a stale match
    o_wdata = ~d;
  endtask

  // index write only
  task automatic idx(input cgr_byte_t a);
    strobe(3'b100, a);
  endtask

  task automatic wr(input cgr_byte_t a, input cgr_byte_t d);
    strobe(3'b100, a);
    strobe(3'b010, d);
  endtask

  // read strobe, data taken one cycle later
  task automatic rd(output cgr_byte_t q);
    strobe(3'b001, o_wdata);
    @(negedge i_clk);
    q = i_rdata;
  endtask

  task automatic move_base(input logic [15:0] b);
    wr(8'h26, b[7:0] & 8'hfe);
    wr(8'h27, b[15:8]);
  endtask

  // enter or leave configuration mode
  task automatic mode(input logic m);
    @(negedge i_clk);
    o_cfg_mode = m;
  endtask
endmodule

`default_nettype wire

// >>> dv/tb.sv
/*
  Self-checking bench for the upper global configuration registers.
  Assumes cgr_pkg and the host model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  import cgr_pkg::*;
  logic i_clk, i_rstn, i_standby_por, i_bus_reset, i_soft_reset, i_cfg_strap;
  logic cfg_mode, index_wr, data_wr, data_rd, io_valid;
  cgr_byte_t wdata, rdata, q, ix, d;
  logic [15:0] io_addr, cfg_base, exp_base, m;
  logic pm_f, pm_p, pm_s1, pm_s2, pm_m, pll, osc_stop, baud, qual, kbc, ihit, dhit;
  int mismatches, compares, seed, n;
  // expected register image
  cgr_byte_t exp_reg [0:255];

  // 20 MHz clock
  initial i_clk = 1'b0;
  always #25 i_clk = ~i_clk;

  cgr_host_model host (.i_clk(i_clk), .i_rdata(rdata), .o_cfg_mode(cfg_mode),
    .o_index_wr(index_wr), .o_data_wr(data_wr), .o_data_rd(data_rd), .o_wdata(wdata));

  cgr_global_regs DUT (.i_clk(i_clk), .i_rstn(i_rstn), .i_standby_por(i_standby_por),
    .i_bus_reset(i_bus_reset), .i_soft_reset(i_soft_reset), .i_cfg_strap(i_cfg_strap),
    .i_cfg_mode(cfg_mode), .i_index_wr(index_wr), .i_data_wr(data_wr),
    .i_data_rd(data_rd), .i_wdata(wdata), .i_io_valid(io_valid), .i_io_addr(io_addr),
    .o_rdata(rdata), .o_floppy_autopm(pm_f), .o_parallel_autopm(pm_p),
    .o_serial1_autopm(pm_s1), .o_serial2_autopm(pm_s2), .o_midi_autopm(pm_m),
    .o_pll_stop(pll), .o_osc_stop(osc_stop), .o_baud_clock_generator_en(baud),
    .o_addr16_qual(qual), .o_kbc_reset(kbc), .o_cfg_base(cfg_base),
    .o_index_hit(ihit), .o_data_hit(dhit));

  // writable bits per index
  function automatic cgr_byte_t wmask(input cgr_byte_t a);
    case (a)
      8'h23: return 8'h79;
      8'h24: return 8'h4e;
      8'h26: return 8'hfe;
      8'h27, 8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h2f: return 8'hff;
      // reserved and unmapped places keep zero
      default: return 8'h00;
    endcase
  endfunction

  // closing report
  task automatic give_verdict();
    if (mismatches == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one counted comparison
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    compares++;
    if (s !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // expected effect of a reset: 0 main, 1 standby, 2 bus
  task automatic exp_reset(input int kind);
    exp_reg[8'h23] = 8'h00;
    exp_reg[8'h24] = 8'h44;
    if (kind != 2)
      for (int k = 8'h2a; k <= 8'h2f; k++) exp_reg[k] = 8'h00;
    if (kind != 1)
    begin
      exp_reg[8'h26] = i_cfg_strap ? 8'h4e : 8'h2e;
      exp_reg[8'h27] = 8'h00;
      exp_base = {8'h00, exp_reg[8'h26]};
    end
  endtask

  // write through the ports and track the image
  task automatic wr_exp(input cgr_byte_t a, input cgr_byte_t v);
    host.wr(a, v);
    exp_reg[a] = v & wmask(a);
    if (a == 8'h27)
      exp_base = {exp_reg[8'h27], exp_reg[8'h26]};
  endtask

  // level outputs against the image
  task automatic chk_out();
    chk("autopm", exp_reg[8'h23], {1'b0, pm_m, pm_s2, pm_s1, pm_p, 2'b00, pm_f});
    chk("pll_stop", exp_reg[8'h24][1], pll);
    chk("osc_stop", exp_reg[8'h24][3:2] == 2'b11, osc_stop);
    chk("baud_en", exp_reg[8'h24][3:2] != 2'b11, baud);
    chk("qual16", exp_reg[8'h24][6], qual);
    chk("kbc_reset", exp_reg[8'h2c][6], kbc);
    chk("cfg_base", exp_base, cfg_base);
  endtask

  // decode at base, base+1, a bit-12 alias and a random address
  task automatic chk_dec();
    for (int k = 0; k < 4; k++)
    begin
      @(negedge i_clk);
      io_valid = (k < 3) | 1'($random(seed));
      io_addr = (k == 3) ? 16'($random(seed)) : (exp_base ^ {3'b000, k[1], 11'h000, k[0]});
      m = exp_reg[8'h24][6] ? 16'hffff : 16'h0fff;
      #1;
      chk("index_hit", io_valid && !io_addr[0] && ((io_addr ^ exp_base) & m) == 0, ihit);
      chk("data_hit", io_valid && io_addr[0] && ((io_addr ^ exp_base ^ 1) & m) == 0, dhit);
    end
  endtask

  // read back every place 0x20..0x30
  task automatic chk_all();
    for (int k = 8'h20; k <= 8'h30; k++)
    begin
      host.idx(8'(k));
      host.rd(q);
      chk("readback", exp_reg[k], q);
    end
    chk_out();
  endtask

  // one-cycle synchronous reset pulse on falling edges
  task automatic pulse(input int kind);
    @(negedge i_clk);
    {i_bus_reset, i_standby_por, i_soft_reset} = 3'b100 >> kind;
    @(negedge i_clk);
    {i_bus_reset, i_standby_por, i_soft_reset} = 3'b000;
  endtask

  // hang guard
  initial
  begin
    repeat (40000) @(posedge i_clk);
    mismatches++;
    give_verdict();
  end

  initial
  begin
    seed = 25;
    mismatches = 0;
    compares = 0;
    i_rstn = 1'b0;
    {i_bus_reset, i_standby_por, i_soft_reset, i_cfg_strap, io_valid} = 5'b00000;
    io_addr = 16'h0000;
    for (int k = 0; k < 256; k++) exp_reg[k] = 8'h00;
    exp_reset(0);
    repeat (12) @(negedge i_clk);
    i_rstn = 1'b1;
    repeat (2) @(negedge i_clk);
    host.mode(1'b1);
    chk_all();
    // every oscillator code
    for (int c = 0; c < 4; c++)
    begin
      wr_exp(8'h24, 8'(c << 2) | 8'hb1);
      chk_out();
    end
    // random writes, reserved and unmapped indices among them
    for (n = 0; n < 80; n++)
    begin
      ix = 8'h20 + 8'($random(seed) & 8'h1f);
      d = 8'($random(seed));
      wr_exp(ix, d);
      host.rd(q);
      chk("rdback", exp_reg[ix], q);
      chk_out();
      chk_dec();
    end
    // strobes outside configuration mode are ignored
    host.mode(1'b0);
    host.wr(8'h23, 8'hff);
    host.wr(8'h2c, ~exp_reg[8'h2c]);
    host.mode(1'b1);
    chk_all();
    host.move_base(16'h1e6a);
    exp_reg[8'h26] = 8'h6a;
    exp_reg[8'h27] = 8'h1e;
    exp_base = 16'h1e6a;
    wr_exp(8'h2c, 8'h40);
    chk_out();
    // soft reset drops the index only
    host.idx(8'h2c);
    pulse(2);
    host.rd(q);
    chk("soft_idx", 8'h00, q);
    chk_all();
    // standby reset keeps the address
    pulse(1);
    exp_reset(1);
    chk_all();
    wr_exp(8'h2d, 8'h5a);
    wr_exp(8'h24, 8'h48);
    // only hold bit, so a kept kbc hold is visible after bus reset
    wr_exp(8'h2c, 8'h40);
    // bus reset with the strap high keeps test registers
    i_cfg_strap = 1'b1;
    pulse(0);
    exp_reset(2);
    chk_all();
    chk_dec();
    // main power-on reset in mid-run: test bytes and address back to defaults
    @(negedge i_clk);
    i_cfg_strap = 1'b0;
    i_rstn = 1'b0;
    repeat (3) @(negedge i_clk);
    i_rstn = 1'b1;
    exp_reset(0);
    repeat (2) @(negedge i_clk);
    chk_all();
    chk_dec();
    give_verdict();
  end
endmodule

`default_nettype wire
